// >>> src/dmcsa_config_regs.sv
// register bank for offline diagnostics, supply/pump monitors and shunt amplifiers
//
// What this block does
// - register 0x23 holds pull-up/pull-down source enables for bridges 1-4, pull-up high
// - per-bridge sources act only while the global diagnostic enable is one
// - all eight diagnostic source enables clear on reset
// - bit 7 selects supply undervoltage latched (0) or auto recovery (1)
// - bits 6-5: latched, auto, warning only, disabled; reset 00
// - overvoltage must persist 1/2/4/8 us per bits 4-3; reset 4 us
// - bit 2 selects overvoltage threshold 21.5 V or 28.5 V; reset high
// - bit 1 selects pump undervoltage latched (0) or auto recovery (1)
// - bit 0 selects pump undervoltage threshold 4.75 V or 6.25 V
// - monitor control register 0x25 resets to 0x14
// - divider bit zero gives reference half, one gives eighth; bits 5 and 2
// - gain fields 4-3 and 1-0 decode 10/20/40/80 V/V, reset 01
// - gain register 0x26 bits 7-6 read zero, resets to 0x09
// - blanking register 0x27: zero bits 7-6, trigger select, duration, reset zero
// - trigger select 000-111 picks half-bridge 1-8 as blanking start
// - duration: disabled, 25, 37.5, 50, 62.5, 75, 87.5, 100 percent of drive time
`timescale 1ns/100ps
module dmcsa_config_regs (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dmcsa_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [dmcsa_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic [dmcsa_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic supplyUvRaw,
   input wire logic supplyOvRaw,
   input wire logic pumpUvRaw,
   output logic [7:0] diagSourceEn,
   output logic supplyOvThreshHigh,
   output logic pumpUvThreshHigh,
   output logic supplyUvFault,
   output logic supplyOvFault,
   output logic supplyOvWarning,
   output logic pumpUvFault,
   output dmcsa_pkg::dmcsa_amp_s amp1Cfg,
   output dmcsa_pkg::dmcsa_amp_s amp2Cfg,
   output dmcsa_pkg::dmcsa_blank_s amp1Blank,
   output logic irq
);
   import dmcsa_pkg::*;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] gainToVv(input logic [1:0] code);
      logic [6:0] vv;
      case (code)
         2'h0: vv = GAIN_VV_10;
         2'h1: vv = GAIN_VV_20;
         2'h2: vv = GAIN_VV_40;
         default: vv = GAIN_VV_80;
      endcase
      return vv;
   endfunction
   function automatic logic [DG_W-1:0] deglitchCycles(input logic [1:0] code);
      logic [DG_W-1:0] cyc;
      case (code)
         2'h0: cyc = DG_1US_CYC;
         2'h1: cyc = DG_2US_CYC;
         2'h2: cyc = DG_4US_CYC;
         default: cyc = DG_8US_CYC;
      endcase
      return cyc;
   endfunction
   // blanking duration in eighths of the gate drive time; 0 = disabled
   function automatic logic [3:0] blankEighths(input logic [2:0] code);
      return (code == 3'h0) ? 4'h0 : 4'({1'b0, code}) + 4'h1;
   endfunction

   function automatic dmcsa_amp_s ampDecode(input logic divBit, input logic [1:0] gain);
      dmcsa_amp_s a;
      a.refDivEighth = divBit;
      a.gainCode = gain;
      a.gainVv = gainToVv(gain);
      return a;
   endfunction

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [REG_W-1:0] diagSrc_reg;
   logic [REG_W-1:0] supplyMon_reg;
   logic [REG_W-1:0] ampGain_reg;
   logic [REG_W-1:0] amp1Blank_reg;
   logic [REG_W-1:0] control_reg;
   logic [REG_W-1:0] irqStatus_reg;
   logic [REG_W-1:0] irqStatus_next;
   logic [REG_W-1:0] irqEnable_reg;
   logic ack_reg;
   logic [WB_DAT_W-1:0] rdData_reg;
   logic faultClear_reg;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic [IDX_W-1:0] regIdx;
   logic busReq;
   logic wrStrobe;
   logic [REG_W-1:0] wrByte;
   logic [REG_W-1:0] rdByte;
   logic [REG_W-1:0] faultVector;
   logic [REG_W-1:0] eventVector;
   logic [REG_W-1:0] irqClearMask;

   assign regIdx = wb_adr_i[WB_ADR_W-1:2];
   assign busReq = wb_cyc_i && wb_stb_i;
   // a write takes effect on the edge at which ack is sampled high
   assign wrStrobe = busReq && wb_we_i && ack_reg && wb_sel_i[0];
   assign wrByte = wb_dat_i[REG_W-1:0];

   // ----------------------------------------------------------------
   // wishbone handshake: ack one cycle after the request, then drop
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= busReq && !ack_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_reg <= '0;
      end else if (busReq && !ack_reg) begin
         rdData_reg <= {{(WB_DAT_W-REG_W){1'b0}}, rdByte};
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdData_reg;

   // ----------------------------------------------------------------
   // read mux: reserved bits and unmapped indices read zero
   // ----------------------------------------------------------------
   always_comb begin
      rdByte = '0;
      case (regIdx)
         IDX_DIAG_SRC: rdByte = diagSrc_reg;
         IDX_SUPPLY_MON: rdByte = supplyMon_reg;
         IDX_AMP_GAIN: rdByte = ampGain_reg & MASK_AMP_GAIN;
         IDX_AMP1_BLANK: rdByte = amp1Blank_reg & MASK_AMP1_BLANK;
         IDX_CONTROL: rdByte = control_reg & MASK_CONTROL;
         IDX_FAULT: rdByte = faultVector;
         IDX_IRQ_STATUS: rdByte = irqStatus_reg;
         IDX_IRQ_ENABLE: rdByte = irqEnable_reg;
         default: rdByte = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // diagnostic source enables
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         diagSrc_reg <= RST_DIAG_SRC;
      end else if (wrStrobe && regIdx == IDX_DIAG_SRC) begin
         diagSrc_reg <= wrByte;
      end
   end

   // ----------------------------------------------------------------
   // supply and pump monitor control
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         supplyMon_reg <= RST_SUPPLY_MON;
      end else if (wrStrobe && regIdx == IDX_SUPPLY_MON) begin
         supplyMon_reg <= wrByte;
      end
   end

   // ----------------------------------------------------------------
   // amplifier gain / reference and amplifier 1 blanking
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ampGain_reg <= RST_AMP_GAIN;
      end else if (wrStrobe && regIdx == IDX_AMP_GAIN) begin
         ampGain_reg <= wrByte & MASK_AMP_GAIN;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         amp1Blank_reg <= RST_AMP1_BLANK;
      end else if (wrStrobe && regIdx == IDX_AMP1_BLANK) begin
         amp1Blank_reg <= wrByte & MASK_AMP1_BLANK;
      end
   end

   // ----------------------------------------------------------------
   // control: global diagnostic enable and fault clear command
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         control_reg <= RST_CONTROL;
         faultClear_reg <= 1'b0;
      end else begin
         faultClear_reg <= wrStrobe && regIdx == IDX_CONTROL && wrByte[CTRL_CLEAR_BIT];
         if (wrStrobe && regIdx == IDX_CONTROL) begin
            control_reg <= wrByte & MASK_CONTROL;
         end
      end
   end

   // ----------------------------------------------------------------
   // monitor mode decode
   // ----------------------------------------------------------------
   dmcsa_ov_mode_e ovMode;
   logic supplyUvAuto;
   logic pumpUvAuto;
   logic ovAuto;
   logic ovOff;
   logic [DG_W-1:0] ovDgCycles;

   assign ovMode = dmcsa_ov_mode_e'(supplyMon_reg[SUPPLY_OV_MODE_LSB +: 2]);
   assign supplyUvAuto = supplyMon_reg[SUPPLY_UV_MODE_BIT];
   assign pumpUvAuto = supplyMon_reg[PUMP_UV_MODE_BIT];
   assign ovDgCycles = deglitchCycles(supplyMon_reg[SUPPLY_OV_DG_LSB +: 2]);

   assign ovAuto = (ovMode == OV_AUTO) || (ovMode == OV_WARN_ONLY);
   assign ovOff = (ovMode == OV_OFF);

   // ----------------------------------------------------------------
   // monitor channels
   // ----------------------------------------------------------------
   logic supplyUvLevel;
   logic supplyUvEvent;
   logic supplyOvLevel;
   logic supplyOvEvent;
   logic pumpUvLevel;
   logic pumpUvEvent;

   dmcsa_monitor_chan supplyUvChan (
      .sys_clk(sys_clk),
      .rst(rst),
      .condRaw(supplyUvRaw),
      .dgCycles(UV_DG_CYC),
      .autoRecover(supplyUvAuto),
      .monitorOff(1'b0),
      .faultClear(faultClear_reg),
      .faultLevel(supplyUvLevel),
      .faultEvent(supplyUvEvent)
   );
   dmcsa_monitor_chan supplyOvChan (
      .sys_clk(sys_clk),
      .rst(rst),
      .condRaw(supplyOvRaw),
      .dgCycles(ovDgCycles),
      .autoRecover(ovAuto),
      .monitorOff(ovOff),
      .faultClear(faultClear_reg),
      .faultLevel(supplyOvLevel),
      .faultEvent(supplyOvEvent)
   );
   dmcsa_monitor_chan pumpUvChan (
      .sys_clk(sys_clk),
      .rst(rst),
      .condRaw(pumpUvRaw),
      .dgCycles(UV_DG_CYC),
      .autoRecover(pumpUvAuto),
      .monitorOff(1'b0),
      .faultClear(faultClear_reg),
      .faultLevel(pumpUvLevel),
      .faultEvent(pumpUvEvent)
   );

   // warning-only mode reports but never raises the fault
   logic ovWarnMode;
   assign ovWarnMode = (ovMode == OV_WARN_ONLY);

   always_comb begin
      faultVector = '0;
      faultVector[EV_SUPPLY_UV] = supplyUvLevel;
      faultVector[EV_SUPPLY_OV] = supplyOvLevel && !ovWarnMode;
      faultVector[EV_OV_WARN] = supplyOvLevel && ovWarnMode;
      faultVector[EV_PUMP_UV] = pumpUvLevel;
      eventVector = '0;
      eventVector[EV_SUPPLY_UV] = supplyUvEvent;
      eventVector[EV_SUPPLY_OV] = supplyOvEvent && !ovWarnMode;
      eventVector[EV_OV_WARN] = supplyOvEvent && ovWarnMode;
      eventVector[EV_PUMP_UV] = pumpUvEvent;
   end

   // ----------------------------------------------------------------
   // interrupts: sticky status, write-one clear, enable mask
   // ----------------------------------------------------------------
   assign irqClearMask = (wrStrobe && regIdx == IDX_IRQ_CLEAR) ? wrByte : '0;
   // set wins over a clear in the same cycle
   assign irqStatus_next = ((irqStatus_reg & ~irqClearMask) | eventVector) & MASK_EVENTS;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqStatus_reg <= RST_IRQ;
      end else begin
         irqStatus_reg <= irqStatus_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqEnable_reg <= RST_IRQ;
      end else if (wrStrobe && regIdx == IDX_IRQ_ENABLE) begin
         irqEnable_reg <= wrByte & MASK_EVENTS;
      end
   end

   assign irq = |(irqStatus_reg & irqEnable_reg);

   // ----------------------------------------------------------------
   // output staging
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         diagSourceEn <= '0;
         supplyOvThreshHigh <= RST_SUPPLY_MON[SUPPLY_OV_THR_BIT];
         pumpUvThreshHigh <= RST_SUPPLY_MON[PUMP_UV_THR_BIT];
      end else begin
         diagSourceEn <= control_reg[CTRL_GLOBAL_BIT] ? diagSrc_reg : '0;
         supplyOvThreshHigh <= supplyMon_reg[SUPPLY_OV_THR_BIT];
         pumpUvThreshHigh <= supplyMon_reg[PUMP_UV_THR_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         supplyUvFault <= 1'b0;
         supplyOvFault <= 1'b0;
         supplyOvWarning <= 1'b0;
         pumpUvFault <= 1'b0;
      end else begin
         supplyUvFault <= faultVector[EV_SUPPLY_UV];
         supplyOvFault <= faultVector[EV_SUPPLY_OV];
         supplyOvWarning <= faultVector[EV_OV_WARN];
         pumpUvFault <= faultVector[EV_PUMP_UV];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         amp1Cfg <= ampDecode(RST_AMP_GAIN[AMP1_DIV_BIT], RST_AMP_GAIN[AMP1_GAIN_LSB +: 2]);
         amp2Cfg <= ampDecode(RST_AMP_GAIN[AMP2_DIV_BIT], RST_AMP_GAIN[AMP2_GAIN_LSB +: 2]);
      end else begin
         amp1Cfg <= ampDecode(ampGain_reg[AMP1_DIV_BIT],
            ampGain_reg[AMP1_GAIN_LSB +: 2]);
         amp2Cfg <= ampDecode(ampGain_reg[AMP2_DIV_BIT],
            ampGain_reg[AMP2_GAIN_LSB +: 2]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         amp1Blank <= '0;
      end else begin
         amp1Blank.triggerBridge <= amp1Blank_reg[BLANK_SEL_LSB +: 3];
         amp1Blank.durationCode <= amp1Blank_reg[BLANK_DUR_LSB +: 3];
         amp1Blank.durationEighths <= blankEighths(amp1Blank_reg[BLANK_DUR_LSB +: 3]);
         amp1Blank.active <= |amp1Blank_reg[BLANK_DUR_LSB +: 3];
      end
   end

endmodule

// >>> src/dmcsa_monitor_chan.sv
// one voltage monitor channel: pin synchroniser, deglitch and latched/auto fault flag
`timescale 1ns/100ps
module dmcsa_monitor_chan (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic condRaw,
   input wire logic [dmcsa_pkg::DG_W-1:0] dgCycles,
   input wire logic autoRecover,
   input wire logic monitorOff,
   input wire logic faultClear,
   output logic faultLevel,
   output logic faultEvent
);
   import dmcsa_pkg::*;

   logic [2:0] sync_reg;
   logic cond_reg;
   logic [DG_W-1:0] dgCount_reg;
   logic fault_reg;
   logic event_reg;
   logic qualified;
   logic faultSet;
   logic faultDrop;

   // ----------------------------------------------------------------
   // synchroniser: second and third stage must agree
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync_reg <= 3'h0;
         cond_reg <= 1'b0;
      end else begin
         sync_reg <= {sync_reg[1:0], condRaw};
         if (sync_reg[1] == sync_reg[2]) begin
            cond_reg <= sync_reg[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // deglitch: condition must persist dgCycles cycles
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || monitorOff || !cond_reg) begin
         dgCount_reg <= '0;
      end else if (dgCount_reg < dgCycles) begin
         dgCount_reg <= dgCount_reg + 10'h001;
      end
   end

   assign qualified = cond_reg && (dgCount_reg >= dgCycles);
   assign faultSet = qualified && !monitorOff;
   assign faultDrop = monitorOff || (!qualified && (autoRecover || faultClear));

   // ----------------------------------------------------------------
   // fault flag: set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fault_reg <= 1'b0;
         event_reg <= 1'b0;
      end else begin
         event_reg <= faultSet && !fault_reg;
         if (faultSet) begin
            fault_reg <= 1'b1;
         end else if (faultDrop) begin
            fault_reg <= 1'b0;
         end
      end
   end

   assign faultLevel = fault_reg;
   assign faultEvent = event_reg;

endmodule

// >>> src/dmcsa_pkg.sv
// constants, types and layouts shared by the diagnostic/monitor/amplifier register block
package dmcsa_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int WB_ADR_W = 10;
   localparam int WB_DAT_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 8;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_DIAG_SRC = 8'h23;
   localparam logic [IDX_W-1:0] IDX_SUPPLY_MON = 8'h25;
   localparam logic [IDX_W-1:0] IDX_AMP_GAIN = 8'h26;
   localparam logic [IDX_W-1:0] IDX_AMP1_BLANK = 8'h27;
   localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h40;
   localparam logic [IDX_W-1:0] IDX_FAULT = 8'h41;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h42;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 8'h43;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'h44;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [REG_W-1:0] RST_DIAG_SRC = 8'h00;
   localparam logic [REG_W-1:0] RST_SUPPLY_MON = 8'h14;
   localparam logic [REG_W-1:0] RST_AMP_GAIN = 8'h09;
   localparam logic [REG_W-1:0] RST_AMP1_BLANK = 8'h00;
   localparam logic [REG_W-1:0] RST_CONTROL = 8'h00;
   localparam logic [REG_W-1:0] RST_IRQ = 8'h00;
   localparam logic [REG_W-1:0] MASK_AMP_GAIN = 8'h3F;
   localparam logic [REG_W-1:0] MASK_AMP1_BLANK = 8'h3F;
   localparam logic [REG_W-1:0] MASK_CONTROL = 8'h01;
   localparam logic [REG_W-1:0] MASK_EVENTS = 8'h0F;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SUPPLY_UV_MODE_BIT = 7;
   localparam int SUPPLY_OV_MODE_LSB = 5;
   localparam int SUPPLY_OV_DG_LSB = 3;
   localparam int SUPPLY_OV_THR_BIT = 2;
   localparam int PUMP_UV_MODE_BIT = 1;
   localparam int PUMP_UV_THR_BIT = 0;
   localparam int AMP1_DIV_BIT = 5;
   localparam int AMP1_GAIN_LSB = 3;
   localparam int AMP2_DIV_BIT = 2;
   localparam int AMP2_GAIN_LSB = 0;
   localparam int BLANK_SEL_LSB = 3;
   localparam int BLANK_DUR_LSB = 0;
   localparam int CTRL_GLOBAL_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int EV_SUPPLY_UV = 0;
   localparam int EV_SUPPLY_OV = 1;
   localparam int EV_OV_WARN = 2;
   localparam int EV_PUMP_UV = 3;

   // ----------------------------------------------------------------
   // gain values in V/V
   // ----------------------------------------------------------------
   localparam logic [6:0] GAIN_VV_10 = 7'h0A;
   localparam logic [6:0] GAIN_VV_20 = 7'h14;
   localparam logic [6:0] GAIN_VV_40 = 7'h28;
   localparam logic [6:0] GAIN_VV_80 = 7'h50;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int DG_1US_NS = 1000;
   localparam int DG_2US_NS = 2000;
   localparam int DG_4US_NS = 4000;
   localparam int DG_8US_NS = 8000;
   localparam int DG_W = 10;
   localparam logic [DG_W-1:0] DG_1US_CYC = DG_W'((DG_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [DG_W-1:0] DG_2US_CYC = DG_W'((DG_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [DG_W-1:0] DG_4US_CYC = DG_W'((DG_4US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [DG_W-1:0] DG_8US_CYC = DG_W'((DG_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [DG_W-1:0] UV_DG_CYC = 10'h001;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {OV_LATCHED, OV_AUTO, OV_WARN_ONLY, OV_OFF} dmcsa_ov_mode_e;

   typedef struct packed {
      logic refDivEighth;
      logic [1:0] gainCode;
      logic [6:0] gainVv;
   } dmcsa_amp_s;

   typedef struct packed {
      logic [2:0] triggerBridge;
      logic [2:0] durationCode;
      logic [3:0] durationEighths;
      logic active;
   } dmcsa_blank_s;

endpackage

// >>> test/dmcsa_config_regs_props.sv
// concurrent checks on the ports of the register block
`timescale 1ns/100ps
module dmcsa_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dmcsa_pkg::WB_DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic supplyOvRaw,
   input wire logic [7:0] diagSourceEn,
   input wire logic supplyOvThreshHigh,
   input wire logic pumpUvThreshHigh,
   input wire logic supplyOvFault,
   input wire dmcsa_pkg::dmcsa_amp_s amp1Cfg,
   input wire dmcsa_pkg::dmcsa_amp_s amp2Cfg,
   input wire dmcsa_pkg::dmcsa_blank_s amp1Blank,
   input wire logic irq
);
   import dmcsa_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_ACK_AFTER_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_RSV_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_RST_VALUES: assert property ($past(rst) |-> diagSourceEn == 8'h00 &&
      supplyOvThreshHigh && !pumpUvThreshHigh && amp1Cfg.gainCode == 2'h1)
      else $error("bad value after reset");
   AST_AMP1_GAIN: assert property (amp1Cfg.gainVv == (7'h0A << amp1Cfg.gainCode))
      else $error("amp1 gain decode");
   AST_AMP2_GAIN: assert property (amp2Cfg.gainVv == (7'h0A << amp2Cfg.gainCode))
      else $error("amp2 gain decode");
   AST_BLANK_DECODE: assert property (amp1Blank.active ==
      (amp1Blank.durationCode != 3'h0) && amp1Blank.durationEighths ==
      (amp1Blank.active ? {1'b0, amp1Blank.durationCode} + 4'h1 : 4'h0))
      else $error("blanking decode");
   AST_OV_DEGLITCH: assert property ($rose(supplyOvFault) |-> $past(supplyOvRaw, 4) &&
      $past(supplyOvRaw, 120)) else $error("overvoltage fault too early");
   AST_DIAG_BY_WRITE: assert property ($changed(diagSourceEn) |->
      $past(wb_ack_o, 2) && $past(wb_we_i, 2)) else $error("diag sources moved without write");
   AST_AMP_BY_WRITE: assert property ($changed(amp1Cfg) |->
      ($past(wb_ack_o) && $past(wb_we_i)) || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)))
      else $error("amp1 config moved without write");
   cover property (wb_ack_o && wb_we_i);
   cover property ($rose(supplyOvFault));
   cover property ($fell(irq));
endmodule

// >>> test/tb.sv
// self-checking bench for the register block
`timescale 1ns/100ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
   import dmcsa_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq;
   logic [9:0] wb_adr_i = 10'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, q;
   logic supplyUvRaw = 1'b0, supplyOvRaw = 1'b0, pumpUvRaw = 1'b0;
   logic [7:0] diagSourceEn;
   logic supplyOvThreshHigh, pumpUvThreshHigh, supplyUvFault, supplyOvFault;
   logic supplyOvWarning, pumpUvFault;
   dmcsa_amp_s amp1Cfg, amp2Cfg;
   dmcsa_blank_s amp1Blank;
   logic [6:0] gv [4] = '{GAIN_VV_10, GAIN_VV_20, GAIN_VV_40, GAIN_VV_80};
   logic [3:0] ev [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   int errors = 0, nCompared = 0;
   dmcsa_config_regs u_dmcsa_config_regs (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supplyUvRaw(supplyUvRaw),
      .supplyOvRaw(supplyOvRaw), .pumpUvRaw(pumpUvRaw), .diagSourceEn(diagSourceEn),
      .supplyOvThreshHigh(supplyOvThreshHigh), .pumpUvThreshHigh(pumpUvThreshHigh),
      .supplyUvFault(supplyUvFault), .supplyOvFault(supplyOvFault),
      .supplyOvWarning(supplyOvWarning), .pumpUvFault(pumpUvFault), .amp1Cfg(amp1Cfg),
      .amp2Cfg(amp2Cfg), .amp1Blank(amp1Blank), .irq(irq));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one classic cycle; entered right after a rising edge
   task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h000000, d};
      do begin
         @(posedge sys_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) errors++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      acc(1'b0, idx, 8'h00);
      `CHK("read data", e, q)
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      wrap_up();
   end
   initial begin
      wt(8);
      rst <= 1'b0;
      wt(1);
      rd(8'h23, 32'h00);
      rd(8'h25, 32'h14);
      rd(8'h26, 32'h09);
      rd(8'h27, 32'h00);
      `CHK("ov thr", 1'b1, supplyOvThreshHigh)
      `CHK("amp1 cfg", {1'b0, 2'h1, GAIN_VV_20}, amp1Cfg)
      acc(1'b1, 8'h26, 8'hFF);
      rd(8'h26, 32'h3F);
      acc(1'b1, 8'h30, 8'hFF);
      rd(8'h30, 32'h00);
      acc(1'b1, 8'h23, 8'hA5);
      wt(2);
      `CHK("diag gated", 8'h00, diagSourceEn)
      acc(1'b1, 8'h40, 8'h01);
      wt(2);
      `CHK("diag on", 8'hA5, diagSourceEn)
      wb_sel_i <= 4'hE;
      acc(1'b1, 8'h23, 8'h00);
      wb_sel_i <= 4'hF;
      wt(2);
      `CHK("sel gated", 8'hA5, diagSourceEn)
      $display("test regs done");
      for (int g = 0; g < 4; g++) begin
         acc(1'b1, 8'h26, {3'b001, g[1:0], 1'b1, g[1:0]});
         wt(2);
         `CHK("amp1 cfg", {1'b1, g[1:0], gv[g]}, amp1Cfg)
         `CHK("amp2 cfg", {1'b1, g[1:0], gv[g]}, amp2Cfg)
      end
      for (int b = 0; b < 8; b++) begin
         acc(1'b1, 8'h27, {2'b11, 3'(7 - b), b[2:0]});
         rd(8'h27, {26'h0, 3'(7 - b), b[2:0]});
         `CHK("blank", {3'(7 - b), b[2:0], ev[b], b != 0}, amp1Blank)
      end
      $display("test decode done");
      acc(1'b1, 8'h44, 8'h08);
      pumpUvRaw <= 1'b1;
      wt(10);
      `CHK("irq set", 1'b1, irq)
      pumpUvRaw <= 1'b0;
      wt(10);
      `CHK("pump latched", 1'b1, pumpUvFault)
      acc(1'b1, 8'h44, 8'h00);
      `CHK("irq masked", 1'b0, irq)
      acc(1'b1, 8'h40, 8'h02);
      wt(2);
      `CHK("fault cleared", 1'b0, pumpUvFault)
      acc(1'b1, 8'h44, 8'h08);
      `CHK("irq sticky", 1'b1, irq)
      acc(1'b1, 8'h43, 8'h08);
      `CHK("irq cleared", 1'b0, irq)
      acc(1'b1, 8'h25, 8'h17);
      wt(2);
      `CHK("pump thr", 1'b1, pumpUvThreshHigh)
      pumpUvRaw <= 1'b1;
      wt(10);
      `CHK("pump auto set", 1'b1, pumpUvFault)
      pumpUvRaw <= 1'b0;
      wt(10);
      `CHK("pump auto", 1'b0, pumpUvFault)
      acc(1'b1, 8'h25, 8'h40);
      wt(2);
      `CHK("ov thr", 1'b0, supplyOvThreshHigh)
      supplyOvRaw <= 1'b1;
      wt(100);
      `CHK("ov early", 1'b0, supplyOvWarning)
      wt(60);
      `CHK("ov warn", 2'b01, {supplyOvFault, supplyOvWarning})
      acc(1'b1, 8'h25, 8'h60);
      wt(160);
      `CHK("ov off", 2'b00, {supplyOvFault, supplyOvWarning})
      acc(1'b1, 8'h25, 8'h00);
      wt(160);
      `CHK("ov latched", 1'b1, supplyOvFault)
      rd(8'h41, 32'h02);
      supplyUvRaw <= 1'b1;
      wt(10);
      `CHK("uv set", 1'b1, supplyUvFault)
      supplyUvRaw <= 1'b0;
      wt(10);
      `CHK("uv latched", 1'b1, supplyUvFault)
      acc(1'b1, 8'h25, 8'h80);
      wt(2);
      `CHK("uv auto", 1'b0, supplyUvFault)
      supplyOvRaw <= 1'b0;
      $display("test monitors done");
      wrap_up();
   end
endmodule
bind dmcsa_config_regs dmcsa_props u_dmcsa_props (.sys_clk(sys_clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .supplyOvRaw(supplyOvRaw), .diagSourceEn(diagSourceEn),
   .supplyOvThreshHigh(supplyOvThreshHigh), .pumpUvThreshHigh(pumpUvThreshHigh),
   .supplyOvFault(supplyOvFault), .amp1Cfg(amp1Cfg), .amp2Cfg(amp2Cfg),
   .amp1Blank(amp1Blank), .irq(irq));
